// [dv/rtcv_regs_properties.sv]
/* rtcv_regs_chk: bus answer and readback field checks on rtcv_regs ports.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module rtcv_regs_chk (
    input wire logic        clk_i,   // clock
    input wire logic        rst_i,   // sync reset
    input wire logic        cyc_i,   // bus cycle
    input wire logic        stb_i,   // bus strobe
    input wire logic        we_i,    // write enable
    input wire logic [7:0]  adr_i,   // byte address
    input wire logic [31:0] dat_o,   // read data
    input wire logic        ack_o,   // acknowledge
    input wire logic        alarm_o  // alarm pulse
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // a taken request is answered on the very next edge
    property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    // ack stands one cycle even with the strobe still up
    property p_ack_once; ack_o |=> !ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held");
    // read data is quiet outside an answer
    property p_idle_zero; !ack_o |-> dat_o == 32'h0; endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("data not idle");
    // low nibble of the address picks the layout below the control word
    property p_sec_bits; ack_o && $past(!we_i && adr_i < 8'h28 && adr_i[3:0] == 4'h0)
        |-> (dat_o & 32'hffff80ff) == 32'h0; endproperty
    a_sec_bits: assert property (p_sec_bits) else $error("seconds spare bits");
    property p_hm_bits; ack_o && $past(!we_i && adr_i < 8'h28 && adr_i[3:0] == 4'h4)
        |-> (dat_o & 32'hffffc080) == 32'h0; endproperty
    a_hm_bits: assert property (p_hm_bits) else $error("hour spare bits");
    property p_day_bits; ack_o && $past(!we_i && adr_i < 8'h20 && adr_i[3:0] == 4'h8)
        |-> (dat_o & 32'hffffc0f8) == 32'h0; endproperty
    a_day_bits: assert property (p_day_bits) else $error("day spare bits");
    property p_ym_bits; ack_o && $past(!we_i && adr_i < 8'h20 && adr_i[3:0] == 4'hc)
        |-> (dat_o & 32'hffff00e0) == 32'h0; endproperty
    a_ym_bits: assert property (p_ym_bits) else $error("month spare bits");
    // alarm is a single-cycle pulse
    property p_alarm_once; alarm_o |=> !alarm_o; endproperty
    a_alarm_once: assert property (p_alarm_once) else $error("alarm held");
endmodule // rtcv_regs_chk
bind rtcv_regs rtcv_regs_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
    .alarm_o(alarm_o));

// [dv/rtcv_regs_tb.sv]
/* rtcv_regs_tb: directed wishbone tests of the bcd value registers.
   assumes rtcv_regs, its package and its checker are compiled first. */
`timescale 1ns/1ps
module rtcv_regs_tb;
    localparam int H = 200;      // short half second keeps the run brief
    logic        clk_i = 1'b0;   // clock
    logic        rst_i = 1'b1;   // reset
    logic        cyc_i = 1'b0;   // cycle
    logic        stb_i = 1'b0;   // strobe
    logic        we_i = 1'b0;    // write
    logic [7:0]  adr_i = 8'h00;  // address
    logic [3:0]  sel_i = 4'h0;   // selects
    logic [31:0] dat_i = 32'h0;  // write data
    logic        stamp_i = 1'b0; // capture trigger
    logic [31:0] dat_o;          // read data
    logic        ack_o;          // ack
    logic        alarm_o;        // alarm pulse
    logic [15:0] v;              // last read
    logic [15:0] msk [4] = '{16'h7f00, 16'h3f7f, 16'h3f07, 16'hff1f}; // layouts
    logic [15:0] roll [4] = '{16'h0000, 16'h0000, 16'h0100, 16'h2601}; // after wrap
    int          n_fail = 0;     // mismatches
    int          check_count = 0; // compares
    int          n;              // pulse count
    always #5 clk_i = ~clk_i;
    rtcv_regs #(.HALF_CYC_P(H)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .stamp_i(stamp_i), .dat_o(dat_o), .ack_o(ack_o), .alarm_o(alarm_o));
    // verdict and end of run
    task automatic stop_test;
        $display("checks %0d fails %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // one classic cycle, held until ack is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
        int t = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'h3;
        dat_i <= {16'h0, d};
        do begin
            @(posedge clk_i);
            t++;
        end while (ack_o !== 1'b1 && t < 20);
        if (ack_o !== 1'b1) begin
            n_fail++;             // lost answer
            $display("BAD %0t no ack at %h", $time, a);
        end
        v = dat_o[15:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);             // idle cycle between requests
    endtask
    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 16'h0);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] e);
        check_count++;
        if (got !== e) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, got, e);
        end
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 6; i++) begin
            rd(8'h10 + 8'(4 * i));
            chk(v, 16'h0000);
            xfer(1'b1, 8'h10 + 8'(4 * i), 16'hffff);
            rd(8'h10 + 8'(4 * i));
            chk(v, msk[i % 4]);
        end
        stamp_i <= 1'b1;      // capture off, so stamp words keep storage
        @(posedge clk_i);
        stamp_i <= 1'b0;
        rd(8'h20);
        chk(v, 16'h7f00);
        xfer(1'b1, 8'h30, 16'hffff); // unmapped word
        rd(8'h30);
        chk(v, 16'h0000);
        $display("end of layout tests");
        // 23:59:59, day 31, month 12; the seconds write restarts the half count
        xfer(1'b1, 8'h00, 16'h5900);
        xfer(1'b1, 8'h04, 16'h2359);
        xfer(1'b1, 8'h08, 16'h3106);
        xfer(1'b1, 8'h0c, 16'h2512);
        repeat (H) @(posedge clk_i);
        rd(8'h2c);
        chk(v & 16'h0003, 16'h0001);
        repeat (H - 30) @(posedge clk_i);
        rd(8'h2c);
        chk(v & 16'h0003, 16'h0003);
        repeat (20) @(posedge clk_i);
        for (int i = 0; i < 4; i++) begin
            rd(8'(4 * i));
            chk(v, roll[i]);
        end
        repeat (H) @(posedge clk_i); // into the second half
        xfer(1'b1, 8'h00, 16'h0000);
        rd(8'h2c);
        chk(v & 16'h0001, 16'h0000);
        // 09:59:59 rolls to 10:00:00 and must leave the date alone
        xfer(1'b1, 8'h00, 16'h5900);
        xfer(1'b1, 8'h04, 16'h0959);
        repeat (2 * H + 10) @(posedge clk_i);
        rd(8'h04);
        chk(v, 16'h1000);
        rd(8'h08);
        chk(v, 16'h0100);
        xfer(1'b1, 8'h04, 16'h0000); // back to midnight for the alarm tests
        $display("end of time tests");
        // alarm set to 00:00:01 on the wrapped date, so codes 1 to 9 match once
        xfer(1'b1, 8'h10, 16'h0100);
        xfer(1'b1, 8'h14, 16'h0000);
        xfer(1'b1, 8'h18, 16'h0100);
        xfer(1'b1, 8'h1c, 16'h2601);
        for (int i = 0; i < 11; i++) begin
            xfer(1'b1, 8'h28, (i < 10) ? 16'(i) : 16'h000f);
            xfer(1'b1, 8'h00, 16'h0000);
            n = 0;
            repeat (3 * H + H / 2) begin
                @(posedge clk_i);
                if (alarm_o === 1'b1) n++;
            end
            chk(16'(n), (i == 0) ? 16'h0003 : (i < 10) ? 16'h0001 : 16'h0000);
        end
        rd(8'h2c);
        chk(v & 16'h0004, 16'h0004);
        xfer(1'b1, 8'h2c, 16'h0004);
        rd(8'h2c);
        chk(v & 16'h0004, 16'h0000);
        $display("end of alarm tests");
        xfer(1'b1, 8'h28, 16'h0010);
        xfer(1'b1, 8'h00, 16'h4200);
        xfer(1'b1, 8'h04, 16'h1234);
        stamp_i <= 1'b1;
        @(posedge clk_i);
        stamp_i <= 1'b0;
        rd(8'h2c);
        chk(v & 16'h0008, 16'h0008);
        rd(8'h20);
        chk(v, 16'h4200);
        rd(8'h24);
        chk(v, 16'h1234);
        xfer(1'b1, 8'h2c, 16'h0008);
        rd(8'h2c);
        chk(v & 16'h0008, 16'h0000);
        $display("end of stamp tests");
        stop_test;
    end
    // watchdog: the tests need about 9k cycles
    initial begin
        repeat (40000) @(posedge clk_i);
        n_fail++;
        $display("BAD %0t watchdog expired", $time);
        stop_test;
    end
endmodule // rtcv_regs_tb

// [logic/rtcv_pkg.sv]
/*
 * rtcv_pkg: register map, field positions, masks and timing counts for the
 * bcd time, alarm and stamp value registers.
 * assumes a 32-bit wishbone slave, one register per aligned word.
 */
package rtcv_pkg;
    // byte addresses of the value registers
    localparam logic [7:0] ADR_CUR_SEC  = 8'h00;
    localparam logic [7:0] ADR_CUR_HM   = 8'h04;
    localparam logic [7:0] ADR_CUR_DAY  = 8'h08;
    localparam logic [7:0] ADR_CUR_YM   = 8'h0c;
    localparam logic [7:0] ADR_ALM_SEC  = 8'h10;
    localparam logic [7:0] ADR_ALM_HM   = 8'h14;
    localparam logic [7:0] ADR_ALM_DAY  = 8'h18;
    localparam logic [7:0] ADR_ALM_YM   = 8'h1c;
    localparam logic [7:0] ADR_STP_SEC  = 8'h20;
    localparam logic [7:0] ADR_STP_HM   = 8'h24;
    localparam logic [7:0] ADR_CTRL     = 8'h28;
    localparam logic [7:0] ADR_STAT     = 8'h2c;
    // implemented-bit masks per layout
    localparam logic [15:0] MSK_SEC = 16'h7f00;
    localparam logic [15:0] MSK_HM  = 16'h3f7f;
    localparam logic [15:0] MSK_DAY = 16'h3f07;
    localparam logic [15:0] MSK_YM  = 16'hff1f;
    localparam logic [15:0] MSK_CTL = 16'h001f;
    localparam logic [15:0] RST_VAL = 16'h0000;
    // control register fields
    localparam int CTL_AMSK_LSB = 0;
    localparam int CTL_STEN_BIT = 4;
    // status register fields
    localparam int ST_HALF_BIT = 0;
    localparam int ST_SYNC_BIT = 1;
    localparam int ST_ALM_BIT  = 2;
    localparam int ST_STP_BIT  = 3;
    // timing: half second at 100 MHz
    localparam int  CLK_HZ     = 100_000_000;
    localparam int  HALF_MS    = 500;
    localparam int  HALF_CYC   = CLK_HZ / 1000 * HALF_MS;
    localparam int  SYNC_CYC   = 32;
endpackage : rtcv_pkg

// [logic/rtcv_regs.sv]
/*
 * rtcv_regs: bcd current time/date, alarm and stamp registers with
 * one-second advance, alarm compare and stamp capture.
 * assumes a classic wishbone master and a synchronous active-high reset
 * that stands for power-on reset.
 */
// Local design decisions: the Wishbone slave port and the register addresses.
// Summary of operation
// - hours bcd: tens 13-12, units 11-8
// - minutes bcd: tens 6-4, units 3-0
// - day of month bcd: tens 13-12, units 11-8
// - weekday bits 2-0, values 0 to 6
// - year bcd: tens 15-12, units 11-8
// - month bcd: tens bit 4, units 3-0
// - seconds bcd: tens 14-12, units 11-8
// - unimplemented bits always read zero
// - stamp registers free storage when capture off
// - alarm registers writable, zero at reset
// - stamp registers writable, capture time, zero reset
// - sync flag marks time registers may change
// - seconds units write clears half-second phase
// - alarm fires on masked digit match
// - stamp valid once event flag reads one
`timescale 1ns/1ps
module rtcv_regs #(
    parameter int HALF_CYC_P = rtcv_pkg::HALF_CYC   // half-second length, cycles
) (
    input  wire logic        clk_i,    // 100 MHz clock
    input  wire logic        rst_i,    // sync reset, active high
    input  wire logic        cyc_i,    // wishbone cycle
    input  wire logic        stb_i,    // wishbone strobe
    input  wire logic        we_i,     // write enable
    input  wire logic [7:0]  adr_i,    // byte address
    input  wire logic [3:0]  sel_i,    // byte selects
    input  wire logic [31:0] dat_i,    // write data
    input  wire logic        stamp_i,  // stamp capture trigger, level
    output logic      [31:0] dat_o,    // read data
    output logic             ack_o,    // bus acknowledge
    output logic             alarm_o   // alarm match pulse
);
    // register file: 0 sec,1 hm,2 day,3 ym cur; 4-7 alarm; 8,9 stamp; 10 ctrl
    logic [15:0] reg_q [11];              // value registers
    logic [15:0] reg_d [11];              // next values
    logic        ack_q, ack_d;            // bus ack
    logic [31:0] rdat_q, rdat_d;          // read data register
    logic [31:0] cnt_q, cnt_d;            // half-second counter
    logic        half_q, half_d;          // half_second_phase
    logic        alm_q, alm_d;            // alarm event flag
    logic        stev_q, stev_d;          // stamp_event_flag
    logic        apls_q, apls_d;          // alarm pulse out
    logic        stin_q, stin_d;          // stamp trigger previous level
    logic        tick, htick;             // second / half-second ticks
    logic        tkd_q, tkd_d;            // second tick one cycle late
    logic        match;                   // masked alarm compare
    logic        wr, rd;                  // decoded bus strobes

    // mask of implemented bits per register index
    // spare bits are dropped on write as well as on read, so they read zero
    function automatic logic [15:0] imask(input int i);
        case (i)
            0, 4, 8: imask = rtcv_pkg::MSK_SEC;
            1, 5, 9: imask = rtcv_pkg::MSK_HM;
            2, 6:    imask = rtcv_pkg::MSK_DAY;
            3, 7:    imask = rtcv_pkg::MSK_YM;
            default: imask = rtcv_pkg::MSK_CTL;
        endcase
    endfunction

    // byte-lane merge of low 16 bits
    // only the low two lanes carry a register; sel[3:2] are ignored
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
        merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // bcd digit increment with wrap limit; carry when wrapped
    // no range check: a digit written above its limit wraps on its next increment
    function automatic logic [4:0] binc(input logic [3:0] v,
                                        input logic [3:0] lim,
                                        input logic [3:0] base);
        binc = (v >= lim) ? {1'b1, base} : {1'b0, v + 4'h1};
    endfunction

    // word index from address; 11 means unmapped or status
    // the status word is decoded by its full address, never through the
    // register array, so it cannot be written as plain storage
    function automatic int aidx(input logic [7:0] a);
        aidx = (a[1:0] == 2'b00 && a[7:2] < 6'd11) ? int'(a[7:2]) : 11;
    endfunction

    // bus strobes: a request counts once, in the cycle before ack rises;
    // a master that keeps stb up past ack is taken again and writes a second time
    assign wr = cyc_i && stb_i && we_i && !ack_q;
    assign rd = cyc_i && stb_i && !we_i && !ack_q;
    // half tick ends each half second; the second tick is every other one,
    // taken at the end of the second half so half_second_phase reads 0 first
    assign htick = (cnt_q == 32'(HALF_CYC_P - 1));
    assign tick  = htick && half_q;

    // alarm compare of selected digits; alarm_match_select in ctrl
    // digits are compared one cycle after the second tick, once they have
    // advanced, so the alarm fires in the second that equals the alarm value;
    // comparing at the tick itself would fire one second late
    always_comb begin
        logic [3:0] m;
        logic       s1, s10, mn1, mn10, h, wd, dd, mo;
        m    = reg_q[10][rtcv_pkg::CTL_AMSK_LSB +: 4];
        s1   = reg_q[0][11:8]  == reg_q[4][11:8];
        s10  = reg_q[0][14:12] == reg_q[4][14:12];
        mn1  = reg_q[1][3:0]   == reg_q[5][3:0];
        mn10 = reg_q[1][6:4]   == reg_q[5][6:4];
        h    = reg_q[1][13:8]  == reg_q[5][13:8];
        wd   = reg_q[2][2:0]   == reg_q[6][2:0];
        dd   = reg_q[2][13:8]  == reg_q[6][13:8];
        mo   = reg_q[3][4:0]   == reg_q[7][4:0];
        case (m)
            4'h0: match = htick;
            4'h1: match = tkd_q;
            4'h2: match = tkd_q && s1;
            4'h3: match = tkd_q && s1 && s10;
            4'h4: match = tkd_q && s1 && s10 && mn1;
            4'h5: match = tkd_q && s1 && s10 && mn1 && mn10;
            4'h6: match = tkd_q && s1 && s10 && mn1 && mn10 && h;
            4'h7: match = tkd_q && s1 && s10 && mn1 && mn10 && h && wd;
            4'h8: match = tkd_q && s1 && s10 && mn1 && mn10 && h && dd;
            4'h9: match = tkd_q && s1 && s10 && mn1 && mn10 && h && dd && mo;
            default: match = 1'b0;   // reserved codes never fire
        endcase
    end

    // next state: time advance, bus writes, capture, flags
    // one process computes every next value, so a tick, a capture and a bus
    // write in the same cycle resolve in one place, the write last
    always_comb begin
        logic [4:0] c;
        logic       cy;
        int         wi;
        c  = 5'h00;
        cy = 1'b0;
        wi = aidx(adr_i);
        for (int i = 0; i < 11; i++) begin
            reg_d[i] = reg_q[i];
        end
        cnt_d  = htick ? 32'h0 : cnt_q + 32'h1;
        half_d = htick ? !half_q : half_q;
        // advance digits with decimal carries on the one-second tick
        // seconds and minutes wrap at 59 through binc
        if (tick) begin
            c = binc(reg_q[0][11:8], 4'h9, 4'h0);
            reg_d[0][11:8] = c[3:0];
            cy = c[4];
            if (cy) begin
                c = binc({1'b0, reg_q[0][14:12]}, 4'h5, 4'h0);
                reg_d[0][14:12] = c[2:0];
                cy = c[4];
            end
            if (cy) begin
                c = binc(reg_q[1][3:0], 4'h9, 4'h0);
                reg_d[1][3:0] = c[3:0];
                cy = c[4];
            end
            if (cy) begin
                c = binc({1'b0, reg_q[1][6:4]}, 4'h5, 4'h0);
                reg_d[1][6:4] = c[2:0];
                cy = c[4];
            end
            if (cy) begin
                // hours wrap 23 to 00
                if (reg_q[1][13:8] == 6'h23) begin
                    reg_d[1][13:8] = 6'h00;
                end else if (reg_q[1][11:8] >= 4'h9) begin
                    // 09 to 10 and 19 to 20 stay within the day
                    reg_d[1][13:8] = {reg_q[1][13:12] + 2'h1, 4'h0};
                    cy = 1'b0;
                end else begin
                    reg_d[1][11:8] = reg_q[1][11:8] + 4'h1;
                    cy = 1'b0;
                end
            end
            if (cy) begin
                // weekday wraps 6 to 0
                reg_d[2][2:0] = (reg_q[2][2:0] >= 3'h6) ? 3'h0 : reg_q[2][2:0] + 3'h1;
                // fixed 31-day month keeps the calendar small
                // day 31 wraps to 01 and carries into the month
                if (reg_q[2][13:8] == 6'h31) begin
                    reg_d[2][13:8] = 6'h01;
                end else if (reg_q[2][11:8] >= 4'h9) begin
                    reg_d[2][13:8] = {reg_q[2][13:12] + 2'h1, 4'h0};
                    cy = 1'b0;
                end else begin
                    reg_d[2][11:8] = reg_q[2][11:8] + 4'h1;
                    cy = 1'b0;
                end
            end
            if (cy) begin
                // month 12 wraps to 01 and carries into the year
                if (reg_q[3][4:0] == 5'h12) begin
                    reg_d[3][4:0] = 5'h01;
                end else if (reg_q[3][3:0] >= 4'h9) begin
                    reg_d[3][4:0] = 5'h10;
                    cy = 1'b0;
                end else begin
                    reg_d[3][3:0] = reg_q[3][3:0] + 4'h1;
                    cy = 1'b0;
                end
            end
            if (cy) begin
                // year wraps 99 to 00; there is no century digit
                c = binc(reg_q[3][11:8], 4'h9, 4'h0);
                reg_d[3][11:8] = c[3:0];
                if (c[4]) begin
                    reg_d[3][15:12] = (reg_q[3][15:12] >= 4'h9) ? 4'h0
                                                               : reg_q[3][15:12] + 4'h1;
                end
            end
        end
        // capture on a rising trigger while capture is enabled
        // the trigger is a level: a trigger held high captures only once,
        // and the edge detector idles low like the pin, so reset makes no edge
        stin_d = stamp_i;
        stev_d = stev_q;
        if (reg_q[10][rtcv_pkg::CTL_STEN_BIT] && stamp_i && !stin_q) begin
            reg_d[8] = reg_q[0];
            reg_d[9] = reg_q[1];
        end
        alm_d  = alm_q;
        // software writes; lanes merged, unimplemented bits masked off
        if (wr && wi < 11) begin
            reg_d[wi] = merge(reg_q[wi], dat_i, sel_i) & imask(wi);
            if (wi == 0 && sel_i[1]) begin
                half_d = 1'b0;
                cnt_d  = 32'h0;
            end
        end
        // status write-one-to-clear; a new event wins over the clear
        if (wr && adr_i == rtcv_pkg::ADR_STAT && sel_i[0]) begin
            if (dat_i[rtcv_pkg::ST_ALM_BIT]) alm_d = 1'b0;
            if (dat_i[rtcv_pkg::ST_STP_BIT]) stev_d = 1'b0;
        end
        if (match) alm_d = 1'b1;
        if (reg_q[10][rtcv_pkg::CTL_STEN_BIT] && stamp_i && !stin_q) begin
            stev_d = 1'b1;
        end
        apls_d = match;
        // remember the tick so the alarm compare sees the advanced digits
        tkd_d  = tick;
        // one ack per request; a high ack_q forces the next one to wait
        ack_d  = cyc_i && stb_i && !ack_q;
        // zero unless a read is answered, so idle cycles show zero on the bus
        rdat_d = 32'h0;
        if (rd) begin
            if (wi < 11) begin
                rdat_d = {16'h0, reg_q[wi] & imask(wi)};
            end else if (adr_i == rtcv_pkg::ADR_STAT) begin
                rdat_d[rtcv_pkg::ST_HALF_BIT] = half_q;
                // sync high near the tick edge where digits may change
                rdat_d[rtcv_pkg::ST_SYNC_BIT] =
                    half_q && (cnt_q >= 32'(HALF_CYC_P - rtcv_pkg::SYNC_CYC));
                rdat_d[rtcv_pkg::ST_ALM_BIT] = alm_q;
                rdat_d[rtcv_pkg::ST_STP_BIT] = stev_q;
            end
        end
    end

    // register stage only; every state bit returns to zero on rst_i,
    // which stands for power-on reset, so the stamp words lose their
    // storage here and nowhere else
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 11; i++) begin
                reg_q[i] <= rtcv_pkg::RST_VAL;
            end
            ack_q  <= 1'b0;
            rdat_q <= 32'h0;
            cnt_q  <= 32'h0;
            half_q <= 1'b0;
            alm_q  <= 1'b0;
            stev_q <= 1'b0;
            apls_q <= 1'b0;
            tkd_q  <= 1'b0;
            stin_q <= 1'b0;
        end else begin
            for (int i = 0; i < 11; i++) begin
                reg_q[i] <= reg_d[i];
            end
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
            cnt_q  <= cnt_d;
            half_q <= half_d;
            alm_q  <= alm_d;
            stev_q <= stev_d;
            apls_q <= apls_d;
            tkd_q  <= tkd_d;
            stin_q <= stin_d;
        end
    end

    // every output straight from a flip-flop
    assign ack_o   = ack_q;
    assign dat_o   = rdat_q;
    assign alarm_o = apls_q;
endmodule // rtcv_regs
